// ===== smrc_top.v
// smrc_top.v - supply monitor status flags and reset cause flags, wishbone slave
// assumes: comparator and reset-source levels arrive asynchronously; clk_i is the
// system clock; rst_i is the system reset raised by power-on and low-voltage reset
//
// Notes on behaviour
// - status bits seven to two read as one; writes to them do nothing
// - status bit one is the fall flag, set when supply drops below fall threshold
// - software clears fall and rise flags only by writing zero after reading them as one
// - rise flag sets on recovery after a fall seen with rise enable one
// - fall and rise flags start at zero and low-voltage reset clears them
// - cause bits seven to two are unspecified on read and not writable
// - power-fail flag set by power-on or low-voltage reset; zero write clears
// - watchdog flag set whenever the watchdog timer causes a reset
// - watchdog flag cleared by power-on, low-voltage, external reset or zero write
// - cause flags have no reset value and survive other resets
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

`include "smrc_defines.vh"

module smrc_top #(
  parameter AW = 8
) (
  input  wire          clk_i,
  input  wire          rst_i,
  // wishbone classic slave
  input  wire          cyc_i,
  input  wire          stb_i,
  input  wire          we_i,
  input  wire [AW-1:0] adr_i,
  input  wire [3:0]    sel_i,
  input  wire [31:0]   dat_i,
  output wire [31:0]   dat_o,
  output wire          ack_o,
  // analogue comparators, high while the condition holds
  input  wire          supply_below_fall_i,
  input  wire          supply_above_rise_i,
  // reset sources, high while active
  input  wire          power_on_reset_i,
  input  wire          low_voltage_reset_i,
  input  wire          watchdog_timer_reset_i,
  input  wire          ext_reset_i,
  // interrupt
  output wire          irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  reg         ack_r;
  reg  [31:0] dat_r;
  reg         irq_r;

  wire        acc   = cyc_i & stb_i & ~ack_r;
  wire        rd    = acc & ~we_i;
  // writes land on the edge at which the master samples ack high
  wire        wr    = cyc_i & stb_i & ack_r & we_i & sel_i[0];

  function hit;
    input [AW-1:0] a;
    input [7:0]    ofs;
    begin
      hit = (a == ofs[AW-1:0]);
    end
  endfunction

  wire rd_status = rd & hit(adr_i, `SMRC_ADR_STATUS);
  wire wr_status = wr & hit(adr_i, `SMRC_ADR_STATUS);
  wire wr_cause  = wr & hit(adr_i, `SMRC_ADR_CAUSE);
  wire wr_ctrl   = wr & hit(adr_i, `SMRC_ADR_CTRL);
  wire wr_istat  = wr & hit(adr_i, `SMRC_ADR_IRQ_STAT);
  wire wr_imask  = wr & hit(adr_i, `SMRC_ADR_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and edge detection

  wire [`SMRC_SRC_W-1:0] src_raw;
  wire [`SMRC_SRC_W-1:0] src_s;
  reg  [`SMRC_SRC_W-1:0] src_d_r;
  wire [`SMRC_SRC_W-1:0] src_rise;

  assign src_raw[`SMRC_SRC_FALL] = supply_below_fall_i;
  assign src_raw[`SMRC_SRC_RISE] = supply_above_rise_i;
  assign src_raw[`SMRC_SRC_POR]  = power_on_reset_i;
  assign src_raw[`SMRC_SRC_LVD]  = low_voltage_reset_i;
  assign src_raw[`SMRC_SRC_WDT]  = watchdog_timer_reset_i;
  assign src_raw[`SMRC_SRC_EXT]  = ext_reset_i;

  smrc_sync #(
    .W     (`SMRC_SRC_W)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (src_raw),
    .q_o   (src_s)
  );

  always @(posedge clk_i) begin
    if (rst_i)
      src_d_r <= {`SMRC_SRC_W{1'b0}};
    else
      src_d_r <= src_s;
  end

  assign src_rise = src_s & ~src_d_r;

  wire fall_e = src_rise[`SMRC_SRC_FALL];
  wire up_e   = src_rise[`SMRC_SRC_RISE];
  wire por_e  = src_rise[`SMRC_SRC_POR];
  wire lvd_e  = src_rise[`SMRC_SRC_LVD];
  wire wdt_e  = src_rise[`SMRC_SRC_WDT];
  wire ext_e  = src_rise[`SMRC_SRC_EXT];
  wire lvd_s  = src_s[`SMRC_SRC_LVD];

  ////////////////////////////////////////////////////////////////////////////
  // voltage_monitor_control

  reg rise_irq_enable_r;

  always @(posedge clk_i) begin
    if (rst_i)
      rise_irq_enable_r <= `SMRC_RST_CTRL;
    else if (wr_ctrl)
      rise_irq_enable_r <= dat_i[`SMRC_CTRL_RISE_EN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply_voltage_status flags

  wire flag_clr = rst_i | lvd_s;
  wire supply_fall_flag;
  wire supply_rise_flag;
  reg  rise_armed_r;
  wire rise_set = up_e & rise_armed_r;

  // arms on a fall seen with rise enable set; a low-voltage reset disarms
  always @(posedge clk_i) begin
    if (flag_clr)
      rise_armed_r <= 1'b0;
    else if (fall_e && rise_irq_enable_r)
      rise_armed_r <= 1'b1;
    else if (up_e)
      rise_armed_r <= 1'b0;
  end

  smrc_rc_flag u_fall (
    .clk_i    (clk_i),
    .clr_i    (flag_clr),
    .set_i    (fall_e),
    .rd_i     (rd_status),
    .wr_i     (wr_status),
    .wr_val_i (dat_i[`SMRC_FALL_BIT]),
    .q_o      (supply_fall_flag)
  );

  smrc_rc_flag u_rise (
    .clk_i    (clk_i),
    .clr_i    (flag_clr),
    .set_i    (rise_set),
    .rd_i     (rd_status),
    .wr_i     (wr_status),
    .wr_val_i (dat_i[`SMRC_RISE_BIT]),
    .q_o      (supply_rise_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset_cause flags: no reset term, they survive rst_i

  reg power_fail_reset_flag_r;
  reg watchdog_reset_flag_r;

  always @(posedge clk_i) begin
    if (por_e || lvd_e)
      power_fail_reset_flag_r <= 1'b1;
    else if (wr_cause && !dat_i[`SMRC_PFR_BIT])
      power_fail_reset_flag_r <= 1'b0;
  end

  always @(posedge clk_i) begin
    if (wdt_e)
      watchdog_reset_flag_r <= 1'b1;
    else if (por_e || lvd_e || ext_e || (wr_cause && !dat_i[`SMRC_WDR_BIT]))
      watchdog_reset_flag_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status (write one to clear) and mask

  reg  [1:0] irq_stat_r;
  reg  [1:0] irq_mask_r;
  reg  [1:0] irq_stat_nxt;
  reg  [1:0] irq_mask_nxt;
  wire [1:0] irq_ev;

  assign irq_ev[`SMRC_FALL_BIT] = fall_e;
  assign irq_ev[`SMRC_RISE_BIT] = rise_set;

  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (wr_istat)
      irq_stat_nxt = irq_stat_nxt & ~dat_i[1:0];
    irq_stat_nxt = irq_stat_nxt | irq_ev;
    irq_mask_nxt = wr_imask ? dat_i[1:0] : irq_mask_r;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= `SMRC_RST_IRQ;
      irq_mask_r <= `SMRC_RST_IRQ;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r      <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and acknowledge

  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = `SMRC_RST_DAT;
    if (hit(adr_i, `SMRC_ADR_STATUS))
      rd_nxt[7:0] = {`SMRC_STATUS_RSVD, supply_fall_flag, supply_rise_flag};
    else if (hit(adr_i, `SMRC_ADR_CAUSE))
      rd_nxt[7:0] = {`SMRC_CAUSE_RSVD, power_fail_reset_flag_r,
                     watchdog_reset_flag_r};
    else if (hit(adr_i, `SMRC_ADR_CTRL))
      rd_nxt[7:0] = {`SMRC_CTRL_RSVD, rise_irq_enable_r};
    else if (hit(adr_i, `SMRC_ADR_IRQ_STAT))
      rd_nxt[7:0] = {`SMRC_IRQ_RSVD, irq_stat_r};
    else if (hit(adr_i, `SMRC_ADR_IRQ_MASK))
      rd_nxt[7:0] = {`SMRC_IRQ_RSVD, irq_mask_r};
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= `SMRC_RST_DAT;
    end else begin
      ack_r <= acc;
      if (rd)
        dat_r <= rd_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign irq_o = irq_r;

endmodule // smrc_top

`default_nettype wire

// ===== smrc_defines.vh
// smrc_defines.vh - constants for the supply monitor status and reset cause block
// assumes: included by bare name from the smrc_top design file only
`ifndef SMRC_DEFINES_VH
`define SMRC_DEFINES_VH

// register byte addresses on the wishbone bus
`define SMRC_ADR_STATUS     8'h00
`define SMRC_ADR_CAUSE      8'h04
`define SMRC_ADR_CTRL       8'h08
`define SMRC_ADR_IRQ_STAT   8'h0C
`define SMRC_ADR_IRQ_MASK   8'h10

// supply_voltage_status fields
`define SMRC_FALL_BIT       1
`define SMRC_RISE_BIT       0
`define SMRC_STATUS_RSVD    6'h3F
// reset_cause fields
`define SMRC_PFR_BIT        1
`define SMRC_WDR_BIT        0
`define SMRC_CAUSE_RSVD     6'h00
// voltage_monitor_control fields
`define SMRC_CTRL_RISE_EN   0
`define SMRC_CTRL_RSVD      7'h00
// interrupt status and mask use the supply_voltage_status layout
`define SMRC_IRQ_RSVD       6'h00

// reset values
`define SMRC_RST_CTRL       1'h0
`define SMRC_RST_IRQ        2'h0
`define SMRC_RST_DAT        32'h0000_0000

// synchronised source vector positions
`define SMRC_SRC_FALL       0
`define SMRC_SRC_RISE       1
`define SMRC_SRC_POR        2
`define SMRC_SRC_LVD        3
`define SMRC_SRC_WDT        4
`define SMRC_SRC_EXT        5
`define SMRC_SRC_W          6

`endif

// ===== smrc_sync.v
// smrc_sync.v - two flip-flop level synchroniser, one bit per lane
// assumes: single clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module smrc_sync #(
  parameter W = 6
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] q_r;

  // meta_r feeds q_r and nothing else
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      q_r    <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule // smrc_sync

`default_nettype wire

// ===== smrc_rc_flag.v
// smrc_rc_flag.v - sticky flag cleared by writing zero after it was read as one
// assumes: rd_i and wr_i are one-cycle pulses for accesses to the owning register
`timescale 1ns/10ps
`default_nettype none

module smrc_rc_flag (
  input  wire clk_i,
  input  wire clr_i,
  input  wire set_i,
  input  wire rd_i,
  input  wire wr_i,
  input  wire wr_val_i,
  output wire q_o
);

  reg q_r;
  reg seen_r;

  always @(posedge clk_i) begin
    if (clr_i) begin
      q_r    <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      if (set_i)
        q_r <= 1'b1;
      else if (wr_i && !wr_val_i && seen_r)
        q_r <= 1'b0;
      // a read returning one arms the clear; any write disarms it
      if (wr_i)
        seen_r <= 1'b0;
      else if (rd_i && q_r)
        seen_r <= 1'b1;
    end
  end

  assign q_o = q_r;

endmodule // smrc_rc_flag

`default_nettype wire

// ===== smrc_top_asserts.sv
// smrc_top_asserts.sv - port-level assertions for smrc_top
// assumes: bound into smrc_top; one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module smrc_chk #(
  parameter AW = 8
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          cyc_i,
  input wire logic          stb_i,
  input wire logic          we_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [3:0]    sel_i,
  input wire logic [31:0]   dat_i,
  input wire logic [31:0]   dat_o,
  input wire logic          ack_o,
  input wire logic          supply_below_fall_i,
  input wire logic          supply_above_rise_i,
  input wire logic          power_on_reset_i,
  input wire logic          low_voltage_reset_i,
  input wire logic          watchdog_timer_reset_i,
  input wire logic          ext_reset_i,
  input wire logic          irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_ack;
  assign rd_ack = ack_o && cyc_i && stb_i && !we_i;
  ////////////////////////////////////////
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged after one cycle");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  chk_ack_cause: assert property (ack_o |-> $past(stb_i) && cyc_i)
    else $error("acknowledge without request");
  chk_status_ones: assert property (rd_ack && adr_i == 8'h00 |-> dat_o[7:2] == 6'h3F)
    else $error("status upper bits not all one");
  chk_cause_rsvd: assert property (rd_ack && adr_i == 8'h04 |-> dat_o[7:2] == 6'h00)
    else $error("cause upper bits not zero");
  chk_upper_zero: assert property (rd_ack |-> dat_o[31:8] == 24'h0)
    else $error("read data above byte not zero");
  chk_dat_hold: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data changed outside a read");
  chk_rst_quiet: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && !irq_o && dat_o == 32'h0)
    else $error("outputs not cleared by reset");
endmodule // smrc_chk
bind smrc_top smrc_chk #(.AW(AW)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .supply_below_fall_i(supply_below_fall_i), .supply_above_rise_i(supply_above_rise_i),
  .power_on_reset_i(power_on_reset_i), .low_voltage_reset_i(low_voltage_reset_i),
  .watchdog_timer_reset_i(watchdog_timer_reset_i), .ext_reset_i(ext_reset_i),
  .irq_o(irq_o));
`default_nettype wire

// ===== tb_smrc.sv
// tb_smrc.sv - self-checking bench for smrc_top
// assumes: design and checker compiled first; bench acts as wishbone master
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [5:0]  src = 6'h00;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack_o;
  logic        irq_o;
  int          fail_count = 0;
  int          checks_done = 0;
  always #4 clk_i = ~clk_i;
  smrc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .supply_below_fall_i(src[0]), .supply_above_rise_i(src[1]),
    .power_on_reset_i(src[2]), .low_voltage_reset_i(src[3]),
    .watchdog_timer_reset_i(src[4]), .ext_reset_i(src[5]), .irq_o(irq_o));
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ack and read data are sampled at the edge, before the slave updates them
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    if (ack_o !== 1'b1) begin
      fail_count++;
      give_verdict;
    end else begin
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(nm, rd, {24'h0, exp});
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    src[i] <= 1'b1;
    repeat (3) @(posedge clk_i);
    src[i] <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    rdchk("status reset", 8'h00, 8'hFC);
    wr(8'h00, 8'hFF);
    rdchk("status ro bits", 8'h00, 8'hFC);
    bus(1'b1, 8'h08, 8'h01, 4'h0);
    rdchk("ctrl sel0 low", 8'h08, 8'h00);
    rdchk("unmapped", 8'h14, 8'h00);
  endtask
  task automatic t_fall;
    pulse(0);
    rdchk("fall set", 8'h00, 8'hFE);
    wr(8'h00, 8'hFF);
    wr(8'h00, 8'h00);
    rdchk("fall unread clear", 8'h00, 8'hFE);
    wr(8'h00, 8'h00);
    rdchk("fall cleared", 8'h00, 8'hFC);
  endtask
  task automatic t_rise;
    pulse(0);
    pulse(1);
    rdchk("rise disabled", 8'h00, 8'hFE);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h01);
    pulse(1);
    rdchk("rise no fall", 8'h00, 8'hFC);
    pulse(0);
    pulse(1);
    rdchk("rise set", 8'h00, 8'hFF);
    wr(8'h00, 8'h00);
    rdchk("rise cleared", 8'h00, 8'hFC);
  endtask
  task automatic t_irq;
    wr(8'h0C, 8'h03);
    wr(8'h10, 8'h02);
    pulse(0);
    chk("irq unmasked", {31'h0, irq_o}, 32'h1);
    rdchk("irq status", 8'h0C, 8'h02);
    wr(8'h0C, 8'h02);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    wr(8'h10, 8'h00);
    pulse(0);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    rdchk("irq status masked", 8'h0C, 8'h02);
  endtask
  task automatic t_cause;
    pulse(2);
    rdchk("cause por", 8'h04, 8'h02);
    wr(8'h04, 8'h00);
    rdchk("cause cleared", 8'h04, 8'h00);
    pulse(4);
    rdchk("cause wdt", 8'h04, 8'h01);
    do_reset;
    rdchk("cause kept", 8'h04, 8'h01);
    pulse(5);
    rdchk("cause ext clr", 8'h04, 8'h00);
    pulse(4);
    wr(8'h08, 8'h01);
    pulse(0);
    pulse(3);
    pulse(1);
    rdchk("cause lvd", 8'h04, 8'h02);
    rdchk("status lvd", 8'h00, 8'hFC);
    rdchk("rise lost to lvd", 8'h00, 8'hFC);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_fall;
    t_rise;
    t_irq;
    t_cause;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
